// ### dv/scc_host_model.sv
// scc_host_model.sv: host controller driving digital and analog inputs
// assumes the caller steps it from the core clock domain
`timescale 1ns/100ps
`default_nettype none
module scc_host_model (
  // clock
  input wire logic core_clk,
  // levels to the block
  output logic [7:0] din,
  output logic signed [15:0] an1,
  output logic signed [15:0] an2,
  output logic signed [15:0] spd
);
  initial begin
    din = 8'h00;
    an1 = 16'sh0;
    an2 = 16'sh0;
    spd = 16'sh0;
  end
  // levels change just after an edge and hold until the next call
  task automatic put(input logic [7:0] d, input logic signed [15:0] a,
                     input logic signed [15:0] b, input logic signed [15:0] s);
    @(posedge core_clk);
    din <= d;
    an1 <= a;
    an2 <= b;
    spd <= s;
  endtask
endmodule
`default_nettype wire

// ### dv/scc_top_assertions.sv
// scc_top_assertions.sv: port checker for scc_top
// assumes zero-speed threshold and hysteresis keep their reset values
`timescale 1ns/100ps
`default_nettype none
module scc_top_assertions #(
  parameter int ZTH = 10,
  parameter int ZHY = 5
) (
  // clock, reset, bus
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // drive side
  input wire logic clamp_request_input,
  input wire logic signed [15:0] motor_speed,
  input wire logic clamp_active_q,
  input wire logic clamp_hold_pos_q,
  input wire logic [31:0] hold_position_q,
  input wire logic zero_speed_q
);
  logic [15:0] spd_abs;
  assign spd_abs = motor_speed[15] ? 16'(-motor_speed) : motor_speed;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence bus_req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence slow_s;
    (spd_abs < ZTH) [*4];
  endsequence
  sequence fast_s;
    (spd_abs > ZTH + ZHY) [*4];
  endsequence
  ack_timing_a: assert property (bus_req_s |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  ack_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  ack_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  zero_set_a: assert property (slow_s |-> zero_speed_q)
    else $error("zero speed flag missing");
  zero_clear_a: assert property (fast_s |-> !zero_speed_q)
    else $error("zero speed flag stuck");
  clamp_cause_a: assert property (clamp_active_q |-> $past(clamp_request_input))
    else $error("clamp without request input");
  hold_mode_a: assert property (clamp_hold_pos_q |-> clamp_active_q)
    else $error("position hold without clamp");
  hold_stable_a: assert property (clamp_hold_pos_q [*3] |-> $stable(hold_position_q))
    else $error("held position moved");
endmodule
bind scc_top scc_top_assertions u_chk (
  .core_clk(core_clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .clamp_request_input(clamp_request_input),
  .motor_speed(motor_speed), .clamp_active_q(clamp_active_q),
  .clamp_hold_pos_q(clamp_hold_pos_q), .hold_position_q(hold_position_q),
  .zero_speed_q(zero_speed_q));
`default_nettype wire

// ### dv/scc_top_tb_top.sv
// scc_top_tb_top.sv: register and command path tests of scc_top
// assumes the host model drives all digital and analog inputs
`timescale 1ns/100ps
`default_nettype none
`include "scc_defs.vh"
module scc_top_tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [6:0] m_addr = 7'h00;
  logic m_read = 1'b0;
  logic m_write = 1'b0;
  logic [31:0] m_wdata = 32'h0;
  logic [3:0] m_be = 4'hf;
  logic [31:0] rdata, avs_readdata, hold_pos;
  logic [31:0] pos = 32'h0000_1234;
  logic avs_waitrequest, clamp_act, hold_mode, reached, zero;
  logic [7:0] din;
  logic signed [15:0] an1, an2, spd, cmd, trq;
  logic signed [15:0] sp_t [6] = '{16'sh4b0, 16'sh3b6, 16'sh352, 16'sh0, 16'shc, 16'sh14};
  logic [5:0] re_t = 6'h03;
  logic [5:0] ze_t = 6'h18;
  int fail_count = 0;
  int samples_checked = 0;
  always #25 core_clk = ~core_clk;
  scc_top #(.TICK_CYC(20)) u_dut (
    .core_clk(core_clk), .nrst(nrst), .avs_address(m_addr), .avs_read(m_read),
    .avs_write(m_write), .avs_writedata(m_wdata), .avs_byteenable(m_be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .preset_select_low(din[0]), .preset_select_high(din[1]), .force_zero_input(din[2]),
    .direction_invert_input(din[3]), .clamp_request_input(din[4]),
    .emergency_stop(din[5]), .jog_active(din[6]), .demo_active(din[7]),
    .analog_channel_first(an1), .analog_channel_second(an2), .motor_speed(spd),
    .motor_position(pos), .speed_cmd_q(cmd), .torque_analog_q(trq),
    .clamp_active_q(clamp_act), .clamp_hold_pos_q(hold_mode), .hold_position_q(hold_pos),
    .speed_reached_q(reached), .zero_speed_q(zero));
  scc_host_model u_host (.core_clk(core_clk), .din(din), .an1(an1), .an2(an2), .spd(spd));
  // ----
  // tasks
  // ----
  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic rd, input logic [6:0] a, input logic [31:0] d);
    @(posedge core_clk);
    m_addr <= a;
    m_wdata <= d;
    m_read <= rd;
    m_write <= !rd;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    m_read <= 1'b0;
    m_write <= 1'b0;
  endtask
  task automatic rchk(input logic [6:0] a, input logic [31:0] e);
    bus(1'b1, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdata);
  endtask
  task automatic drv(input logic [7:0] d, input logic signed [15:0] s);
    u_host.put(d, 16'sh3e8, 16'sh7d0, s);
  endtask
  task automatic cmdchk(input logic signed [15:0] e);
    repeat (4) @(posedge core_clk);
    chk("speed_cmd", 32'(e), 32'(cmd));
  endtask
  // ----
  // tests
  // ----
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    rchk(`SCC_A_CTRL, 32'h40);
    rchk(`SCC_A_EMG, 32'h3e8);
    rchk(`SCC_A_ZTH, 32'ha);
    rchk(`SCC_A_ZHY, 32'h5);
    rchk(`SCC_A_ACC, 32'h0);
    rchk(`SCC_A_GAIN, 32'h12c);
    rchk(7'h7c, 32'h0);
    bus(1'b0, `SCC_A_EMG, 32'h4e20);
    rchk(`SCC_A_EMG, 32'h2710);
    bus(1'b0, `SCC_A_DEC, 32'h9c40);
    rchk(`SCC_A_DEC, 32'h7530);
    bus(1'b0, `SCC_A_DEC, 32'h0);
    for (int i = 0; i < 4; i++) bus(1'b0, `SCC_A_PRE1 + 7'(4 * i), 32'(100 * (i + 1)));
    bus(1'b0, `SCC_A_CTRL, 32'h41);
    for (int i = 0; i < 4; i++) begin
      drv(8'(i), 16'sh0);
      cmdchk(16'(100 * (i + 1)));
    end
    bus(1'b0, `SCC_A_CTRL, 32'h42);
    for (int i = 0; i < 4; i++) begin
      drv(8'(i), 16'sh0);
      cmdchk(i == 0 ? 16'sh12c : 16'(100 * (i + 1)));
    end
    bus(1'b0, `SCC_A_CTRL, 32'h40);
    drv(8'h00, 16'sh0);
    cmdchk(16'sh12c);
    chk("torque", 32'h7d0, 32'(trq));
    bus(1'b0, `SCC_A_CTRL, 32'h48);
    cmdchk(16'sh258);
    bus(1'b0, `SCC_A_CTRL, 32'h44);
    cmdchk(16'sh0);
    bus(1'b0, `SCC_A_CTRL, 32'h40);
    bus(1'b0, `SCC_A_DEMO, 32'hfa);
    drv(8'h80, 16'sh0);
    cmdchk(16'shfa);
    drv(8'hc0, 16'sh0);
    cmdchk(16'sh64);
    drv(8'h04, 16'sh0);
    cmdchk(16'sh0);
    drv(8'h08, 16'sh0);
    cmdchk(-16'sh12c);
    drv(8'h00, 16'sh0);
    bus(1'b0, `SCC_A_OFS1, 32'hc8);
    cmdchk(16'shf0);
    bus(1'b0, `SCC_A_TRIG, 32'h1);
    cmdchk(16'sh0);
    rchk(`SCC_A_OFS1, 32'h3e8);
    bus(1'b0, `SCC_A_TRIG, 32'h2);
    cmdchk(16'sh0);
    rchk(`SCC_A_OFS2, 32'h7d0);
    bus(1'b0, `SCC_A_ACC, 32'h3e8);
    bus(1'b0, `SCC_A_OFS1, 32'h0);
    repeat (1000) @(posedge core_clk);
    chk("ramp_mid", 32'h1, 32'(cmd > 0 && cmd < 300));
    repeat (1100) @(posedge core_clk);
    chk("ramp_end", 32'h12c, 32'(cmd));
    bus(1'b0, `SCC_A_DEC, 32'h3e8);
    drv(8'h04, 16'sh0);
    repeat (1000) @(posedge core_clk);
    chk("decel_mid", 32'h1, 32'(cmd > 0 && cmd < 300));
    repeat (1100) @(posedge core_clk);
    chk("decel_end", 32'h0, 32'(cmd));
    bus(1'b0, `SCC_A_ACC, 32'h0);
    bus(1'b0, `SCC_A_DEC, 32'h0);
    drv(8'h00, 16'sh0);
    cmdchk(16'sh12c);
    bus(1'b0, `SCC_A_EMG, 32'h0);
    drv(8'h20, 16'sh0);
    cmdchk(16'sh0);
    drv(8'h00, 16'sh0);
    cmdchk(16'sh12c);
    bus(1'b0, `SCC_A_EMG, 32'h3e8);
    drv(8'h20, 16'sh0);
    repeat (1000) @(posedge core_clk);
    chk("estop_mid", 32'h1, 32'(cmd > 0 && cmd < 300));
    repeat (1100) @(posedge core_clk);
    chk("estop_end", 32'h0, 32'(cmd));
    bus(1'b0, `SCC_A_PRE1, 32'h0);
    bus(1'b0, `SCC_A_CTRL, 32'h41);
    drv(8'h10, 16'sh0);
    cmdchk(16'sh0);
    chk("clamp_hold", 32'h3, {30'h0, clamp_act, hold_mode});
    chk("hold_pos", 32'h1234, hold_pos);
    pos <= 32'h0000_5678;
    cmdchk(16'sh0);
    chk("hold_keep", 32'h1234, hold_pos);
    bus(1'b0, `SCC_A_CTRL, 32'h51);
    cmdchk(16'sh0);
    chk("clamp_vel", 32'h2, {30'h0, clamp_act, hold_mode});
    bus(1'b0, `SCC_A_PRE1, 32'h1f4);
    cmdchk(16'sh1f4);
    chk("clamp_off", 32'h0, {31'h0, clamp_act});
    bus(1'b0, `SCC_A_ATH, 32'h3e8);
    bus(1'b0, `SCC_A_AHY, 32'h64);
    for (int i = 0; i < 6; i++) begin
      drv(8'h00, sp_t[i]);
      repeat (4) @(posedge core_clk);
      chk("reached", 32'(re_t[i]), {31'h0, reached});
      chk("zero", 32'(ze_t[i]), {31'h0, zero});
    end
    bus(1'b0, `SCC_A_CTRL, 32'h61);
    repeat (4) @(posedge core_clk);
    chk("reached_inv", 32'h1, {31'h0, reached});
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire

// ### rtl/scc_defs.vh
// scc_defs.vh: register offsets, reset values and timing counts of the
// speed command conditioning block; definitions only
`ifndef SCC_DEFS_VH
`define SCC_DEFS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SCC_A_CTRL 7'h00
`define SCC_A_PRE1 7'h04
`define SCC_A_PRE2 7'h08
`define SCC_A_PRE3 7'h0c
`define SCC_A_PRE4 7'h10
`define SCC_A_OFS1 7'h14
`define SCC_A_OFS2 7'h18
`define SCC_A_TRIG 7'h1c
`define SCC_A_ACC 7'h20
`define SCC_A_DEC 7'h24
`define SCC_A_EMG 7'h28
`define SCC_A_ZTH 7'h2c
`define SCC_A_ZHY 7'h30
`define SCC_A_ATH 7'h34
`define SCC_A_AHY 7'h38
`define SCC_A_GAIN 7'h3c
`define SCC_A_JOG 7'h40
`define SCC_A_DEMO 7'h44
`define SCC_A_STAT 7'h48
`define SCC_A_CMD 7'h4c
// ----------------------------------------
// control register fields
// ----------------------------------------
`define SCC_C_SRC 2:0
`define SCC_C_CHAN 3
`define SCC_C_CLMODE 4
`define SCC_C_APOL 5
`define SCC_C_SPDMODE 6
// ----------------------------------------
// speed sources
// ----------------------------------------
`define SCC_SRC_ANALOG 3'h0
`define SCC_SRC_PRESET 3'h1
`define SCC_SRC_MIX 3'h2
`define SCC_SRC_JOG 3'h3
`define SCC_SRC_DEMO 3'h5
// ----------------------------------------
// reset values and offset trigger codes
// ----------------------------------------
`define SCC_RST_CTRL 32'h0000_0040
`define SCC_RST_RAMP 16'h0000
`define SCC_RST_EMG 16'h03e8
`define SCC_RST_ZTH 16'h000a
`define SCC_RST_ZHY 16'h0005
`define SCC_RST_ATH 16'h0000
`define SCC_RST_AHY 16'h0000
`define SCC_RST_GAIN 16'h012c
`define SCC_RST_JOG 16'h0064
`define SCC_TRIG_FIRST 2'h1
`define SCC_TRIG_SECOND 2'h2
// ----------------------------------------
// write limits and analog scaling
// ----------------------------------------
`define SCC_MAX_RAMP 16'h7530
`define SCC_MAX_EMG 16'h2710
`define SCC_MAX_ZERO 16'h03e8
`define SCC_MIN_GAIN 16'h000a
`define SCC_MAX_GAIN 16'h0bb8
`define SCC_MV_PER_V 34'sh0_0000_03e8
// ----------------------------------------
// timing
// ----------------------------------------
`define SCC_CLK_HZ 20000000
`define SCC_TICK_US 1000
`define SCC_TICK_CYC ((`SCC_CLK_HZ / 1000000) * `SCC_TICK_US)
`define SCC_RATED_RPM 3000
`endif

// ### rtl/scc_top.v
// scc_top.v: speed-mode command source selection, ramp, zero clamp and
// speed comparators, with an Avalon-MM register slave.
// assumes core_clk 20 MHz, all inputs synchronous, speeds in r/min, mV.
// ----------------------------------------
// Overview of operation
// RULE_01 - source 0 takes analog command from the selected channel
// RULE_02 - source 1 picks preset 1..4 from the two preset select inputs
// RULE_03 - source 2: both inputs off gives analog, otherwise presets 2..4
// RULE_04 - jog in progress forces source 3, the jog speed
// RULE_05 - source 4 reserved; demo run forces source 5, demo speed
// RULE_06 - offsets writable; trigger 1 or 2 auto-zeroes channel one or two
// RULE_07 - force-zero input holds the speed command at zero
// RULE_08 - invert input reverses the sign of the speed command
// RULE_09 - accel and decel times 0..30000 ms, rated speed to or from zero
// RULE_10 - slope fixed, so smaller changes finish proportionally sooner
// RULE_11 - host closing a position loop should set both ramp times to 0
// RULE_12 - emergency stop decel time 0..10000 ms, default 1000 ms
// RULE_13 - clamp needs speed mode, clamp input on, command below threshold
// RULE_14 - zero-speed threshold default 10 and hysteresis default 5 r/min
// RULE_15 - clamp mode 0 latches position and holds it by position control
// RULE_16 - clamp mode 1 forces speed command to zero in speed control
// RULE_17 - speed reached when speed exceeds threshold, hysteresis, polarity
// RULE_18 - zero speed when speed below threshold, with hysteresis
// RULE_19 - first channel feeds speed, second feeds torque; the code swaps the two channels when chan_sel is set
// RULE_20 - analog gain 10..3000 rpm per volt, default 300
// RULE_21 - each 1 ms tick steps by rated speed over time; zero time passes
`timescale 1ns/100ps
`default_nettype none
`include "scc_defs.vh"
module scc_top #(
  parameter TICK_CYC = `SCC_TICK_CYC,
  parameter RATED_RPM = `SCC_RATED_RPM
) (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // avalon-mm slave
  input wire [6:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // digital inputs
  input wire preset_select_low,
  input wire preset_select_high,
  input wire force_zero_input,
  input wire direction_invert_input,
  input wire clamp_request_input,
  input wire emergency_stop,
  input wire jog_active,
  input wire demo_active,
  // analog channels and feedback
  input wire signed [15:0] analog_channel_first,
  input wire signed [15:0] analog_channel_second,
  input wire signed [15:0] motor_speed,
  input wire [31:0] motor_position,
  // command outputs
  output reg signed [15:0] speed_cmd_q,
  output reg signed [15:0] torque_analog_q,
  output reg clamp_active_q,
  output reg clamp_hold_pos_q,
  output reg [31:0] hold_position_q,
  output reg speed_reached_q,
  output reg zero_speed_q
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [31:0] ctrl_q;
  reg signed [15:0] pre1_q, pre2_q, pre3_q, pre4_q, ofs1_q, ofs2_q;
  reg [15:0] acc_q, dec_q, emg_q, zth_q, zhy_q, ath_q, ahy_q, gain_q;
  reg signed [15:0] jog_q, demo_q;
  reg [1:0] trig_q;
  reg [31:0] rd_d;
  wire [2:0] src_cfg = ctrl_q[`SCC_C_SRC];
  wire chan_sel = ctrl_q[`SCC_C_CHAN];
  wire clamp_mode = ctrl_q[`SCC_C_CLMODE];
  wire apol = ctrl_q[`SCC_C_APOL];
  wire spd_mode = ctrl_q[`SCC_C_SPDMODE];
  wire bus_req = avs_read | avs_write;
  wire wr_take = avs_write & ~avs_waitrequest;
  // ----------------------------------------
  // command source
  // ----------------------------------------
  reg [2:0] src_eff;
  reg signed [15:0] cmd_sel;
  reg signed [15:0] preset_v;
  wire [1:0] psel = {preset_select_high, preset_select_low};
  wire signed [15:0] ain_first = analog_channel_first - ofs1_q;
  wire signed [15:0] ain_second = analog_channel_second - ofs2_q;
  wire signed [15:0] ain_speed = chan_sel ? ain_second : ain_first; // [RULE_01]
  wire signed [15:0] ain_torque = chan_sel ? ain_first : ain_second; // [RULE_19]
  wire signed [33:0] ain_prod = ain_speed * $signed({1'b0, gain_q}); // [RULE_20]
  wire signed [33:0] ain_rpm = ain_prod / `SCC_MV_PER_V;
  always @* begin
    if (jog_active)
      src_eff = `SCC_SRC_JOG; // [RULE_04]
    else if (demo_active)
      src_eff = `SCC_SRC_DEMO; // [RULE_05]
    else
      src_eff = src_cfg;
    case (psel) // [RULE_02]
      2'h0: preset_v = pre1_q;
      2'h1: preset_v = pre2_q;
      2'h2: preset_v = pre3_q;
      default: preset_v = pre4_q;
    endcase
    case (src_eff)
      `SCC_SRC_ANALOG: cmd_sel = ain_rpm[15:0]; // [RULE_01]
      `SCC_SRC_PRESET: cmd_sel = preset_v; // [RULE_02]
      `SCC_SRC_MIX: cmd_sel = (psel == 2'h0) ? ain_rpm[15:0] : preset_v; // [RULE_03]
      `SCC_SRC_JOG: cmd_sel = jog_q; // [RULE_04]
      `SCC_SRC_DEMO: cmd_sel = demo_q; // [RULE_05]
      default: cmd_sel = 16'sh0000; // [RULE_05]
    endcase
  end
  // ----------------------------------------
  // inhibit, inversion, clamp
  // ----------------------------------------
  wire signed [15:0] cmd_inv = direction_invert_input ? -cmd_sel : cmd_sel; // [RULE_08]
  wire signed [15:0] cmd_pre = force_zero_input ? 16'sh0000 : cmd_inv; // [RULE_07]
  wire [15:0] cmd_abs = cmd_pre[15] ? -cmd_pre : cmd_pre;
  wire clamp_cond = spd_mode & clamp_request_input & (cmd_abs < zth_q); // [RULE_13]
  wire signed [15:0] target = (clamp_cond | emergency_stop) ? 16'sh0000 : cmd_pre; // [RULE_16]
  // ----------------------------------------
  // ramp, 1 ms tick
  // ----------------------------------------
  localparam TICK_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  reg [TICK_W-1:0] tick_cnt_q;
  reg tick_q;
  reg signed [31:0] ramp_q;
  reg signed [31:0] ramp_d;
  wire signed [31:0] tgt_fx = {target, 16'h0000};
  wire away = (target != 16'sh0000) &&
    ((ramp_q == 32'sh0) || (target[15] == ramp_q[31] &&
    (tgt_fx[31] ? tgt_fx < ramp_q : tgt_fx > ramp_q)));
  wire [15:0] ramp_time = emergency_stop ? emg_q : (away ? acc_q : dec_q); // [RULE_12]
  wire [31:0] rated_fx = RATED_RPM * 32'h0001_0000;
  wire [31:0] step = (ramp_time == 16'h0) ? 32'h0 : rated_fx / {16'h0, ramp_time}; // [RULE_10]
  always @* begin
    ramp_d = ramp_q;
    if (ramp_time == 16'h0)
      ramp_d = tgt_fx; // [RULE_21]
    else if (tick_q) begin
      if (tgt_fx > ramp_q)
        ramp_d = (tgt_fx - ramp_q > $signed(step)) ? ramp_q + $signed(step) : tgt_fx; // [RULE_09]
      else if (tgt_fx < ramp_q)
        ramp_d = (ramp_q - tgt_fx > $signed(step)) ? ramp_q - $signed(step) : tgt_fx; // [RULE_09]
    end
  end
  always @(posedge core_clk) begin
    if (!nrst) begin
      tick_cnt_q <= {TICK_W{1'b0}};
      tick_q <= 1'b0;
      ramp_q <= 32'sh0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_CYC - 1);
      tick_cnt_q <= (tick_cnt_q == TICK_CYC - 1) ? {TICK_W{1'b0}} : tick_cnt_q + 1'b1;
      ramp_q <= ramp_d; // [RULE_21]
    end
  end
  // ----------------------------------------
  // command outputs and zero clamp
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!nrst) begin
      speed_cmd_q <= 16'sh0000;
      torque_analog_q <= 16'sh0000;
      clamp_active_q <= 1'b0;
      clamp_hold_pos_q <= 1'b0;
      hold_position_q <= 32'h0000_0000;
    end else begin
      speed_cmd_q <= ramp_d[31:16];
      torque_analog_q <= ain_torque; // [RULE_19]
      clamp_active_q <= clamp_cond; // [RULE_13]
      clamp_hold_pos_q <= clamp_cond & ~clamp_mode; // [RULE_15]
      if (clamp_cond & ~clamp_active_q)
        hold_position_q <= motor_position; // [RULE_15]
    end
  end
  // ----------------------------------------
  // speed comparators
  // ----------------------------------------
  wire [15:0] spd_abs = motor_speed[15] ? -motor_speed : motor_speed;
  wire [16:0] zth_up = {1'b0, zth_q} + {1'b0, zhy_q};
  wire [16:0] ath_dn = ({1'b0, ath_q} > {1'b0, ahy_q}) ? {1'b0, ath_q} - {1'b0, ahy_q} : 17'h0;
  reg arr_q;
  always @(posedge core_clk) begin
    if (!nrst) begin
      arr_q <= 1'b0;
      speed_reached_q <= 1'b0;
      zero_speed_q <= 1'b0;
    end else begin
      if ({1'b0, spd_abs} > {1'b0, ath_q})
        arr_q <= 1'b1; // [RULE_17]
      else if ({1'b0, spd_abs} < ath_dn)
        arr_q <= 1'b0; // [RULE_17]
      speed_reached_q <= apol ? ~arr_q : arr_q; // [RULE_17]
      if (spd_abs < zth_q)
        zero_speed_q <= 1'b1; // [RULE_18]
      else if ({1'b0, spd_abs} > zth_up)
        zero_speed_q <= 1'b0; // [RULE_18]
    end
  end
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wd = avs_writedata & wmask;
  // ----------------------------------------
  // write value limits
  // ----------------------------------------
  wire [15:0] wd_lo = wd[15:0];
  wire [15:0] wd_ramp = (wd_lo > `SCC_MAX_RAMP) ? `SCC_MAX_RAMP : wd_lo;
  wire [15:0] wd_emg = (wd_lo > `SCC_MAX_EMG) ? `SCC_MAX_EMG : wd_lo;
  wire [15:0] wd_zero = (wd_lo > `SCC_MAX_ZERO) ? `SCC_MAX_ZERO : wd_lo;
  wire [15:0] wd_gain = (wd_lo < `SCC_MIN_GAIN) ? `SCC_MIN_GAIN :
    ((wd_lo > `SCC_MAX_GAIN) ? `SCC_MAX_GAIN : wd_lo);
  // ----------------------------------------
  // register readback
  // ----------------------------------------
  always @* begin
    case (avs_address)
      `SCC_A_CTRL: rd_d = ctrl_q;
      `SCC_A_PRE1: rd_d = {16'h0, pre1_q};
      `SCC_A_PRE2: rd_d = {16'h0, pre2_q};
      `SCC_A_PRE3: rd_d = {16'h0, pre3_q};
      `SCC_A_PRE4: rd_d = {16'h0, pre4_q};
      `SCC_A_OFS1: rd_d = {16'h0, ofs1_q};
      `SCC_A_OFS2: rd_d = {16'h0, ofs2_q};
      `SCC_A_TRIG: rd_d = {30'h0, trig_q};
      `SCC_A_ACC: rd_d = {16'h0, acc_q};
      `SCC_A_DEC: rd_d = {16'h0, dec_q};
      `SCC_A_EMG: rd_d = {16'h0, emg_q};
      `SCC_A_ZTH: rd_d = {16'h0, zth_q};
      `SCC_A_ZHY: rd_d = {16'h0, zhy_q};
      `SCC_A_ATH: rd_d = {16'h0, ath_q};
      `SCC_A_AHY: rd_d = {16'h0, ahy_q};
      `SCC_A_GAIN: rd_d = {16'h0, gain_q};
      `SCC_A_JOG: rd_d = {16'h0, jog_q};
      `SCC_A_DEMO: rd_d = {16'h0, demo_q};
      `SCC_A_STAT: rd_d = {25'h0, zero_speed_q, speed_reached_q, clamp_active_q,
        emergency_stop, src_eff};
      `SCC_A_CMD: rd_d = {16'h0, speed_cmd_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end
  always @(posedge core_clk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      ctrl_q <= `SCC_RST_CTRL;
      {pre1_q, pre2_q, pre3_q, pre4_q} <= 64'h0;
      {ofs1_q, ofs2_q, demo_q} <= 48'h0;
      trig_q <= 2'h0;
      acc_q <= `SCC_RST_RAMP;
      dec_q <= `SCC_RST_RAMP;
      emg_q <= `SCC_RST_EMG;
      zth_q <= `SCC_RST_ZTH;
      zhy_q <= `SCC_RST_ZHY;
      ath_q <= `SCC_RST_ATH;
      ahy_q <= `SCC_RST_AHY;
      gain_q <= `SCC_RST_GAIN;
      jog_q <= `SCC_RST_JOG;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (bus_req & avs_waitrequest)
        avs_readdata <= avs_read ? rd_d : 32'h0000_0000;
      if (trig_q == `SCC_TRIG_FIRST) begin
        ofs1_q <= analog_channel_first; // [RULE_06]
        trig_q <= 2'h0;
      end else if (trig_q == `SCC_TRIG_SECOND) begin
        ofs2_q <= analog_channel_second; // [RULE_06]
        trig_q <= 2'h0;
      end
      if (wr_take) begin
        case (avs_address)
          `SCC_A_CTRL: ctrl_q <= (ctrl_q & ~wmask) | (wd & 32'h0000_007f);
          `SCC_A_PRE1: pre1_q <= wd[15:0];
          `SCC_A_PRE2: pre2_q <= wd[15:0];
          `SCC_A_PRE3: pre3_q <= wd[15:0];
          `SCC_A_PRE4: pre4_q <= wd[15:0];
          `SCC_A_OFS1: ofs1_q <= wd[15:0]; // [RULE_06]
          `SCC_A_OFS2: ofs2_q <= wd[15:0]; // [RULE_06]
          `SCC_A_TRIG: trig_q <= wd[1:0]; // [RULE_06]
          `SCC_A_ACC: acc_q <= wd_ramp; // [RULE_09]
          `SCC_A_DEC: dec_q <= wd_ramp; // [RULE_09]
          `SCC_A_EMG: emg_q <= wd_emg; // [RULE_12]
          `SCC_A_ZTH: zth_q <= wd_zero; // [RULE_14]
          `SCC_A_ZHY: zhy_q <= wd_zero; // [RULE_14]
          `SCC_A_ATH: ath_q <= wd[15:0];
          `SCC_A_AHY: ahy_q <= wd[15:0];
          `SCC_A_GAIN: gain_q <= wd_gain; // [RULE_20]
          `SCC_A_JOG: jog_q <= wd[15:0];
          `SCC_A_DEMO: demo_q <= wd[15:0];
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire
